// File: verilog/pcbm_pkg.sv
// package: constants, types and register map of the pulse counter block
//
// Operation
// - Three analog, two digital inputs; each digital has enable and mode.
// - A pulse channel counts any change, rising only or falling only.
// - Each counted edge adds exactly one to the counter, no software help.
// - Each pulse counter is 32 bits wide.
// - At each logging slot the reading is the counter plus the offset.
// - Battery is full when the voltage is at or above the full threshold and above the low threshold.
// - Battery is good when the voltage lies between full and low thresholds.
// - Battery is low when the voltage is at or below the low threshold.
// - Each upload wakeup at low threshold raises a low-battery event.
// - Red while attaching, blue once attached, red flashing if low or no card.
// - On battery power the light is forced off while the device sleeps.
// - On external power the device never sleeps.
package pcbm_pkg;

  localparam int unsigned DI_CHANNELS = 2;
  localparam int unsigned AI_CHANNELS = 3;
  localparam int unsigned CNT_W       = 32;
  localparam int unsigned VOLT_W      = 12;
  localparam int unsigned ADDR_W      = 6;

  // register word offsets (byte addresses)
  localparam logic [5:0] OFS_CTRL     = 6'h00;
  localparam logic [5:0] OFS_STATUS   = 6'h04;
  localparam logic [5:0] OFS_IRQ_STAT = 6'h08;
  localparam logic [5:0] OFS_IRQ_MASK = 6'h0c;
  localparam logic [5:0] OFS_THRESH   = 6'h10;
  localparam logic [5:0] OFS_OFFSET0  = 6'h14;
  localparam logic [5:0] OFS_OFFSET1  = 6'h18;
  localparam logic [5:0] OFS_COUNT0   = 6'h1c;
  localparam logic [5:0] OFS_COUNT1   = 6'h20;
  localparam logic [5:0] OFS_READ0    = 6'h24;
  localparam logic [5:0] OFS_READ1    = 6'h28;
  localparam logic [5:0] OFS_VOLT     = 6'h2c;

  // interrupt status bit positions
  localparam int unsigned IRQ_SLOT   = 0;
  localparam int unsigned IRQ_BATLOW = 1;
  localparam int unsigned IRQ_W      = 2;

  // reset values and the read value of unmapped addresses
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [11:0] FULL_RST   = 12'hfff;
  localparam logic [11:0] LOW_RST    = 12'h000;
  localparam logic [31:0] UNMAPPED   = 32'h0000_0000;

  // flash rate of the status light: half period in ms
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned FLASH_HALF_MS = 500;
  localparam int unsigned FLASH_CYCLES  = CLK_HZ / 1000 * FLASH_HALF_MS;
  localparam int unsigned FLASH_W       = 27;

  typedef enum logic [1:0]
  {
    EDGE_CHANGE  = 2'h0,
    EDGE_RISING  = 2'h1,
    EDGE_FALLING = 2'h2
  } edge_sel_t;

  typedef enum logic [1:0]
  {
    BAT_GOOD = 2'h0,
    BAT_FULL = 2'h1,
    BAT_LOW  = 2'h2
  } bat_state_t;

  typedef enum logic [1:0]
  {
    LED_OFF      = 2'h0,
    LED_RED      = 2'h1,
    LED_BLUE     = 2'h2
  } led_color_t;

  // per-channel configuration, packed into control register bits 3:0 for channel 0 and 7:4 for channel 1
  typedef struct packed
  {
    edge_sel_t  edge_sel;
    logic       pulse_mode;   // 1 pulse counter, 0 dry contact
    logic       enable;
  } di_cfg_t;

  typedef struct packed
  {
    logic [VOLT_W-1:0] full;
    logic [VOLT_W-1:0] low;
  } bat_thresh_t;

  // single-cycle edge checker per selected type
  function automatic logic edge_hit(edge_sel_t sel, logic prev, logic cur);
    logic h;
    h = 1'b0;
    case (sel)
      EDGE_CHANGE:  h = prev ^ cur;
      EDGE_RISING:  h = ~prev & cur;
      EDGE_FALLING: h = prev & ~cur;
      default:      h = 1'b0;
    endcase
    return h;
  endfunction

endpackage

// File: verilog/pulse_channel.sv
// one digital input channel: synchroniser, edge detect, 32-bit counter
`timescale 1ns/1ps
module pulse_channel
(
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  input  wire pcbm_pkg::di_cfg_t        cfg,
  input  wire logic                     pin,
  output logic                          level,
  output logic [pcbm_pkg::CNT_W-1:0]    count
);
  import pcbm_pkg::*;

  logic       sync1_q;
  logic       sync2_q;
  logic       prev_q;
  logic [CNT_W-1:0] count_q;
  logic       hit;

  // two-stage synchroniser, then one stage for edge history
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end
    else
    begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign hit = cfg.enable & cfg.pulse_mode
             & edge_hit(cfg.edge_sel, prev_q, sync2_q);

  // counter adds one per event and wraps naturally
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      count_q <= '0;
    else if (hit)
      count_q <= count_q + CNT_W'(1);
  end

  assign count = count_q;
  assign level = sync2_q & cfg.enable;

  a_count_step: assert property (@(posedge mclk) disable iff (!rst_n)
    hit |=> count_q == $past(count_q) + CNT_W'(1))
    else $error("counter did not step by one");

  a_count_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    !hit |=> count_q == $past(count_q))
    else $error("counter moved without event");

  a_mode_gate: assert property (@(posedge mclk) disable iff (!rst_n)
    !(cfg.enable && cfg.pulse_mode) |=> count_q == $past(count_q))
    else $error("disabled channel counted");

endmodule

// File: verilog/battery_class.sv
// battery voltage classifier against full and low thresholds
`timescale 1ns/1ps
module battery_class
(
  input  wire logic [pcbm_pkg::VOLT_W-1:0] volt,
  input  wire pcbm_pkg::bat_thresh_t       thresh,
  output pcbm_pkg::bat_state_t             state
);
  import pcbm_pkg::*;

  // low checked first so overlapping thresholds read as low
  always_comb
  begin
    if (volt <= thresh.low)
      state = BAT_LOW;
    else if (volt >= thresh.full)
      state = BAT_FULL;
    else
      state = BAT_GOOD;
  end

endmodule

// File: verilog/pulse_counter_battery_monitor.sv
// top: pulse channels, battery status, light, sleep and avalon registers
`timescale 1ns/1ps
module pulse_counter_battery_monitor
(
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic [5:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic [31:0]                      avs_readdata,
  output logic                             avs_waitrequest,
  input  wire logic [1:0]                  digital_input_channel,
  input  wire logic [pcbm_pkg::VOLT_W-1:0] battery_volt,
  input  wire logic                        log_slot,
  input  wire logic                        upload_wake,
  input  wire logic                        ext_power,
  input  wire logic                        net_attached,
  input  wire logic                        sim_present,
  input  wire logic                        sleep_request,
  input  wire logic                        console_source_select_switch,
  output logic                             sleep_active,
  output logic                             led_red,
  output logic                             led_blue,
  output logic                             battery_low_event,
  output logic                             console_wireless,
  output logic [1:0]                       dry_contact_level,
  output logic                             irq
);
  import pcbm_pkg::*;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [31:0]       ctrl_q;
  bat_thresh_t       thresh_q;
  logic [CNT_W-1:0]  offset_q [DI_CHANNELS];
  logic [CNT_W-1:0]  reading_q [DI_CHANNELS];
  logic [CNT_W-1:0]  count_w [DI_CHANNELS];
  logic [IRQ_W-1:0]  istat_q;
  logic [IRQ_W-1:0]  imask_q;
  logic [31:0]       rdata_q;
  logic              rvalid_q;
  logic              sleep_q;
  logic              batlow_q;
  logic              wire_q;
  logic [FLASH_W-1:0] flash_cnt_q;
  logic              flash_q;
  bat_state_t        bat_state;
  di_cfg_t           cfg [DI_CHANNELS];
  logic [IRQ_W-1:0]  ev_set;
  logic              wr_hit;

  // ---------------------------------------------------------------
  // digital channels
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < DI_CHANNELS; g++)
    begin : g_ch
      assign cfg[g] = di_cfg_t'(ctrl_q[g*4 +: 4]);
      pulse_channel u_ch
      (
        .mclk  (mclk),
        .rst_n (rst_n),
        .cfg   (cfg[g]),
        .pin   (digital_input_channel[g]),
        .level (dry_contact_level[g]),
        .count (count_w[g])
      );
    end
  endgenerate

  // reading captured on each logging slot
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < DI_CHANNELS; i++)
        reading_q[i] <= '0;
    end
    else if (log_slot)
    begin
      for (int i = 0; i < DI_CHANNELS; i++)
        reading_q[i] <= count_w[i] + offset_q[i];
    end
  end

  // ---------------------------------------------------------------
  // battery, sleep, light
  // ---------------------------------------------------------------
  battery_class u_bat
  (
    .volt   (battery_volt),
    .thresh (thresh_q),
    .state  (bat_state)
  );

  // low-battery event pulse on each upload wakeup while the battery is low
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      batlow_q <= 1'b0;
    else
      batlow_q <= upload_wake & (bat_state == BAT_LOW);
  end
  assign battery_low_event = batlow_q;

  // sleep only allowed on battery
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      sleep_q <= 1'b0;
    else
      sleep_q <= sleep_request & ~ext_power;
  end
  assign sleep_active = sleep_q;

  // flash divider for the red light
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      flash_cnt_q <= '0;
      flash_q     <= 1'b0;
    end
    else if (flash_cnt_q == FLASH_W'(FLASH_CYCLES - 1))
    begin
      flash_cnt_q <= '0;
      flash_q     <= ~flash_q;
    end
    else
      flash_cnt_q <= flash_cnt_q + FLASH_W'(1);
  end

  // light colour selection
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      led_red  <= 1'b0;
      led_blue <= 1'b0;
    end
    else if (sleep_q)
    begin
      led_red  <= 1'b0;
      led_blue <= 1'b0;
    end
    else if (!sim_present || bat_state == BAT_LOW)
    begin
      led_red  <= flash_q;
      led_blue <= 1'b0;
    end
    else
    begin
      led_red  <= ~net_attached;
      led_blue <= net_attached;
    end
  end

  // console source follows the installer switch
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      wire_q <= 1'b0;
    else
      wire_q <= console_source_select_switch;
  end
  assign console_wireless = wire_q;

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  assign ev_set[IRQ_SLOT]   = log_slot;
  assign ev_set[IRQ_BATLOW] = batlow_q;
  assign wr_hit = avs_write & ~avs_waitrequest;

  // sticky status, set wins over write-one-to-clear
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      istat_q <= '0;
    else if (wr_hit && avs_address == OFS_IRQ_STAT && avs_byteenable[0])
      istat_q <= (istat_q & ~avs_writedata[IRQ_W-1:0]) | ev_set;
    else
      istat_q <= istat_q | ev_set;
  end
  assign irq = |(istat_q & imask_q);

  // ---------------------------------------------------------------
  // avalon slave: one wait cycle on reads, writes immediate
  // ---------------------------------------------------------------
  assign avs_waitrequest = avs_read & ~rvalid_q;

  // configuration writes, byte 0 for control bits
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      ctrl_q   <= CTRL_RST;
      imask_q  <= '0;
      thresh_q <= '{full: FULL_RST, low: LOW_RST};
      for (int i = 0; i < DI_CHANNELS; i++)
        offset_q[i] <= '0;
    end
    else if (wr_hit)
    begin
      case (avs_address)
        OFS_CTRL:
          if (avs_byteenable[0])
            ctrl_q[7:0] <= avs_writedata[7:0];
        OFS_IRQ_MASK:
          if (avs_byteenable[0])
            imask_q <= avs_writedata[IRQ_W-1:0];
        OFS_THRESH:
          if (&avs_byteenable)
            thresh_q <= bat_thresh_t'(avs_writedata[2*VOLT_W-1:0]);
        OFS_OFFSET0:
          if (&avs_byteenable)
            offset_q[0] <= avs_writedata;
        OFS_OFFSET1:
          if (&avs_byteenable)
            offset_q[1] <= avs_writedata;
        default: ;
      endcase
    end
  end

  // read data registered, one cycle after request
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
    end
    else
    begin
      rvalid_q <= avs_read & ~rvalid_q;
      case (avs_address)
        OFS_CTRL:     rdata_q <= ctrl_q;
        OFS_STATUS:   rdata_q <= {26'h0, sleep_q, wire_q,
                                  bat_state, dry_contact_level};
        OFS_IRQ_STAT: rdata_q <= {30'h0, istat_q};
        OFS_IRQ_MASK: rdata_q <= {30'h0, imask_q};
        OFS_THRESH:   rdata_q <= {8'h0, thresh_q};
        OFS_OFFSET0:  rdata_q <= offset_q[0];
        OFS_OFFSET1:  rdata_q <= offset_q[1];
        OFS_COUNT0:   rdata_q <= count_w[0];
        OFS_COUNT1:   rdata_q <= count_w[1];
        OFS_READ0:    rdata_q <= reading_q[0];
        OFS_READ1:    rdata_q <= reading_q[1];
        OFS_VOLT:     rdata_q <= {20'h0, battery_volt};
        default:      rdata_q <= UNMAPPED;
      endcase
    end
  end
  assign avs_readdata = rdata_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_slot_reading: assert property (@(posedge mclk) disable iff (!rst_n)
    log_slot |=> reading_q[0] == $past(count_w[0]) + $past(offset_q[0]))
    else $error("reading is not count plus offset");

  a_batlow_event: assert property (@(posedge mclk) disable iff (!rst_n)
    upload_wake && bat_state == BAT_LOW |=> battery_low_event)
    else $error("low battery event missing on upload");

  a_no_batlow_ok: assert property (@(posedge mclk) disable iff (!rst_n)
    !upload_wake |=> !battery_low_event)
    else $error("low battery event without wakeup");

  a_ext_awake: assert property (@(posedge mclk) disable iff (!rst_n)
    ext_power |=> !sleep_active)
    else $error("slept on external power");

  a_sleep_dark: assert property (@(posedge mclk) disable iff (!rst_n)
    sleep_q |=> !led_red && !led_blue)
    else $error("light on while asleep");

  a_attach_blue: assert property (@(posedge mclk) disable iff (!rst_n)
    !sleep_q && sim_present && bat_state != BAT_LOW && net_attached
    |=> led_blue && !led_red)
    else $error("light not blue when attached");

  a_bat_full: assert property (@(posedge mclk) disable iff (!rst_n)
    battery_volt > thresh_q.low && battery_volt >= thresh_q.full
    |-> bat_state == BAT_FULL)
    else $error("battery not full above threshold");

  a_bat_low: assert property (@(posedge mclk) disable iff (!rst_n)
    battery_volt <= thresh_q.low |-> bat_state == BAT_LOW)
    else $error("battery not low under threshold");

  a_bat_good: assert property (@(posedge mclk) disable iff (!rst_n)
    battery_volt > thresh_q.low && battery_volt < thresh_q.full
    |-> bat_state == BAT_GOOD)
    else $error("battery not good between thresholds");

endmodule

// File: tb/pulse_source.sv
// pulse meter model that drives one digital input with a pulse train
`timescale 1ns/1ps
module pulse_source
(
  input  wire logic       mclk,
  input  wire logic       go,
  input  wire logic [7:0] n,
  input  wire logic [3:0] width,
  output logic            pin,
  output logic            busy
);
  // ---------------------------------------------------------------
  // pulse train
  // ---------------------------------------------------------------
  // on go, n pulses of width cycles high and width low; idle low
  initial
  begin
    pin  = 1'b0;
    busy = 1'b0;
    forever
    begin
      @(posedge mclk);
      if (go)
      begin
        busy <= 1'b1;
        repeat (n)
        begin
          pin <= 1'b1;
          repeat (width) @(posedge mclk);
          pin <= 1'b0;
          repeat (width) @(posedge mclk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule

// File: tb/pulse_counter_battery_monitor_bench.sv
// self-checking bench of the pulse counter and battery monitor
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module pulse_counter_battery_monitor_bench;
  import pcbm_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic        rd_q = 1'b0;
  logic        wr_q = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        wreq;
  logic [1:0]  hi = 2'h0;
  logic [1:0]  go = 2'h0;
  logic [1:0]  pin;
  logic [1:0]  busy;
  logic [11:0] volt = 12'h600;
  logic        slot = 1'b0;
  logic        wake = 1'b0;
  logic        extp = 1'b1;
  logic        attached = 1'b0;
  logic        sim = 1'b1;
  logic        slp_req = 1'b0;
  logic        sw = 1'b0;
  logic        sleep_active, led_red, led_blue, ble, cw, irq;
  logic [1:0]  dry;
  logic [31:0] q;
  int          miscompares = 0;
  int          n_checks = 0;
  int          seen;
  logic [11:0] vt [4] = '{12'h800, 12'h7ff, 12'h400, 12'h401};
  logic [1:0]  st [4] = '{2'h1, 2'h0, 2'h2, 2'h0};

  // ---------------------------------------------------------------
  // clock, partner models and device
  // ---------------------------------------------------------------
  initial
  begin
    forever #5 mclk = ~mclk;
  end

  pulse_source src0 (.mclk(mclk), .go(go[0]), .n(8'h05), .width(4'h2),
                     .pin(pin[0]), .busy(busy[0]));
  pulse_source src1 (.mclk(mclk), .go(go[1]), .n(8'h05), .width(4'h3),
                     .pin(pin[1]), .busy(busy[1]));

  pulse_counter_battery_monitor dut
  (
    .mclk                         (mclk),
    .rst_n                        (rst_n),
    .avs_address                  (adr),
    .avs_read                     (rd_q),
    .avs_write                    (wr_q),
    .avs_writedata                (wdat),
    .avs_byteenable               (4'hf),
    .avs_readdata                 (rdat),
    .avs_waitrequest              (wreq),
    .digital_input_channel        (pin | hi),
    .battery_volt                 (volt),
    .log_slot                     (slot),
    .upload_wake                  (wake),
    .ext_power                    (extp),
    .net_attached                 (attached),
    .sim_present                  (sim),
    .sleep_request                (slp_req),
    .console_source_select_switch (sw),
    .sleep_active                 (sleep_active),
    .led_red                      (led_red),
    .led_blue                     (led_blue),
    .battery_low_event            (ble),
    .console_wireless             (cw),
    .dry_contact_level            (dry),
    .irq                          (irq)
  );

  // ---------------------------------------------------------------
  // bus and helper tasks
  // ---------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // one avalon transfer, entered right after a rising edge; the request
  // stands until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    adr  <= a;
    wdat <= d;
    wr_q <= w;
    rd_q <= ~w;
    do
      @(posedge mclk);
    while (wreq !== 1'b0);
    r = rdat;
    wr_q <= 1'b0;
    rd_q <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [5:0] a);
    bus(1'b0, a, 32'h0, q);
  endtask

  // fire the pulse trains selected by m and wait for them to finish
  task automatic fire(input logic [1:0] m);
    go <= m;
    cyc(1);
    go <= 2'h0;
    cyc(2);
    while (busy !== 2'h0)
      cyc(1);
    cyc(8);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd(OFS_CTRL);
    `CHK("ctrl", 32'h0, q)
    rd(OFS_THRESH);
    `CHK("thresh", 32'h00fff000, q)
    rd(6'h30);
    `CHK("unmapped", 32'h0, q)
    `CHK("irq", 1'b0, irq)
  endtask

  // rising on ch0, falling on ch1, then any change on ch0
  task automatic t_edges;
    wr(OFS_CTRL, 32'h000000b7);
    fire(2'h3);
    rd(OFS_COUNT0);
    `CHK("count0", 32'h5, q)
    hi <= 2'h3;
    cyc(8);
    hi <= 2'h0;
    cyc(8);
    rd(OFS_COUNT0);
    `CHK("count0 rise", 32'h6, q)
    rd(OFS_COUNT1);
    `CHK("count1 fall", 32'h6, q)
    wr(OFS_CTRL, 32'h00000013);
    fire(2'h1);
    rd(OFS_COUNT0);
    `CHK("count0 chg", 32'h10, q)
    hi <= 2'h2;
    cyc(6);
    `CHK("dry level", 2'h2, dry & 2'h2)
    rd(OFS_COUNT1);
    `CHK("count1 dry", 32'h6, q)
    wr(OFS_CTRL, 32'h00000003);
    cyc(4);
    `CHK("dry disabled", 2'h0, dry & 2'h2)
    hi <= 2'h0;
  endtask

  // slot reading wraps past 32 bits, slot interrupt set, masked, cleared
  task automatic t_slot;
    wr(OFS_IRQ_MASK, 32'h3);
    wr(OFS_OFFSET0, 32'hfffffffe);
    slot <= 1'b1;
    cyc(1);
    slot <= 1'b0;
    cyc(3);
    rd(OFS_READ0);
    `CHK("reading0", 32'h0000000e, q)
    `CHK("irq slot", 1'b1, irq)
    wr(OFS_IRQ_MASK, 32'h2);
    cyc(1);
    `CHK("irq masked", 1'b0, irq)
    wr(OFS_IRQ_STAT, 32'h1);
    rd(OFS_IRQ_STAT);
    `CHK("irq cleared", 32'h0, q)
  endtask

  // battery classes at the thresholds and the upload low event
  task automatic t_battery;
    wr(OFS_THRESH, 32'h00800400);
    for (int i = 0; i < 4; i++)
    begin
      volt <= vt[i];
      cyc(4);
      rd(OFS_STATUS);
      `CHK("bat state", st[i], q[3:2])
    end
    for (int i = 0; i < 2; i++)
    begin
      volt <= i ? 12'h400 : 12'h600;
      seen = 0;
      cyc(4);
      wake <= 1'b1;
      cyc(1);
      wake <= 1'b0;
      repeat (6)
      begin
        @(negedge mclk);
        seen += int'(ble === 1'b1);
      end
      @(posedge mclk);
      `CHK("low event", i, seen)
    end
    rd(OFS_IRQ_STAT);
    `CHK("low irq bit", 32'h2, q)
    volt <= 12'h600;
  endtask

  // light and sleep follow supply and network state; console switch
  task automatic t_power;
    slp_req <= 1'b1;
    cyc(4);
    `CHK("no sleep ext", 1'b0, sleep_active)
    `CHK("red attach", 2'h2, {led_red, led_blue})
    attached <= 1'b1;
    sw <= 1'b1;
    cyc(4);
    `CHK("blue", 2'h1, {led_red, led_blue})
    `CHK("console", 1'b1, cw)
    extp <= 1'b0;
    cyc(4);
    `CHK("sleep bat", 1'b1, sleep_active)
    `CHK("light off", 2'h0, {led_red, led_blue})
    extp <= 1'b1;
    sim  <= 1'b0;
    cyc(4);
    `CHK("awake ext", 1'b0, sleep_active)
    `CHK("no card blue", 1'b0, led_blue)
    sim  <= 1'b1;
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    cyc(6);
    rst_n <= 1'b1;
    cyc(1);
    t_reset();
    t_edges();
    t_slot();
    t_battery();
    t_power();
    give_verdict();
  end

  initial
  begin
    cyc(20000);
    miscompares++;
    give_verdict();
  end
endmodule
